// File: rtl/hcw_regs.svh
`ifndef HCW_REGS_SVH
`define HCW_REGS_SVH

// Clock and timing
`define HCW_CLK_HZ 10000000
`define HCW_BASE_PULSE_MS 1000
`define HCW_SEC_PER_HOUR 3600

// Block sizes
`define HCW_NUM_CNT 4
`define HCW_NUM_TS 8
`define HCW_NUM_CH 4
`define HCW_NUM_CFG 32

// Calendar
`define HCW_LAST_MIN 11'h59F
`define HCW_LAST_DAY 3'h6
`define HCW_WEEK_MIN 10080
`define HCW_DAY_MIN 1440

// Register byte offsets (low address byte)
`define HCW_SETPT_BASE 4'h1
`define HCW_ACTUAL_BASE 4'h2
`define HCW_STATUS_ADDR 8'h30
`define HCW_IRQ_STAT_ADDR 8'h34
`define HCW_IRQ_MASK_ADDR 8'h38
`define HCW_CFG_LO 2'h1
`define HCW_CFG_HI 2'h2

// Setpoint register fields
`define HCW_SETPT_W 20
`define HCW_SETPT_SHOW_BIT 31

// Channel configuration fields
`define HCW_CH_FROM_LSB 0
`define HCW_CH_TO_LSB 4
`define HCW_CH_ON_LSB 8
`define HCW_CH_ON_VLD 19
`define HCW_CH_OFF_LSB 20
`define HCW_CH_OFF_VLD 31

// Status register fields
`define HCW_ST_SCAN_BIT 12
`define HCW_ST_PWR_BIT 13

// Reset values
`define HCW_SETPT_RST 32'h00000000
`define HCW_CFG_RST 32'h00000000
`define HCW_MASK_RST 12'h000

`endif

// File: rtl/hcw_pkg.sv
package hcw_pkg;

  typedef logic [31:0] hcw_word_t;

  // Time switch sequencer: unpowered, rebuilding state, running
  typedef enum logic [1:0] {
    HCW_DOWN,
    HCW_SCAN,
    HCW_RUN
  } hcw_ts_state_t;

endpackage

// File: rtl/hcw_prescaler.sv
`timescale 1ns/10ps
`include "hcw_regs.svh"

module hcw_prescaler
  import hcw_pkg::*;
#(
  parameter int unsigned CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  output logic tick
);

  logic [23:0] div_reg;

  // Divider restarts whenever power drops, so a partial second is discarded
  always_ff @(posedge core_clk) begin
    if (!reset_n || !run) begin
      div_reg <= 24'h000000;
    end else if (div_reg == 24'(CYCLES - 1)) begin
      div_reg <= 24'h000000;
    end else begin
      div_reg <= div_reg + 24'h000001;
    end
  end

  // One-cycle base pulse at the end of each whole second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (div_reg == 24'(CYCLES - 1));
    end
  end

endmodule

// File: rtl/hcw_chan_eval.sv
`timescale 1ns/10ps
`include "hcw_regs.svh"

module hcw_chan_eval
  import hcw_pkg::*;
(
  input wire logic [31:0] cfg,
  input wire logic [2:0] day,
  input wire logic [10:0] minute,
  output logic on_hit,
  output logic off_hit
);

  logic [2:0] from_day;
  logic [2:0] to_day;
  logic [2:0] prev_day;
  logic [10:0] on_min;
  logic [10:0] off_min;
  logic on_set;
  logic off_set;
  logic overnight;

  // Day range test; a range such as SA-MO wraps over the week end
  function automatic logic day_in(input logic [2:0] f, input logic [2:0] t, input logic [2:0] d);
    if (f <= t) begin
      return (d >= f) && (d <= t);
    end
    return (d >= f) || (d <= t);
  endfunction

  // Field unpacking
  assign from_day = cfg[`HCW_CH_FROM_LSB +: 3];
  assign to_day = cfg[`HCW_CH_TO_LSB +: 3];
  assign on_min = cfg[`HCW_CH_ON_LSB +: 11];
  assign off_min = cfg[`HCW_CH_OFF_LSB +: 11];
  assign on_set = cfg[`HCW_CH_ON_VLD];
  assign off_set = cfg[`HCW_CH_OFF_VLD];
  assign prev_day = (day == 3'h0) ? `HCW_LAST_DAY : day - 3'h1;

  // Off before on in the day means the off event belongs to the next day
  assign overnight = on_set && (off_min < on_min);
  // Either time may stand alone, the other left unset
  assign on_hit = on_set && (on_min == minute) && day_in(from_day, to_day, day);
  assign off_hit = off_set && (off_min == minute) &&
                   day_in(from_day, to_day, overnight ? prev_day : day);

endmodule

// File: rtl/hcw_top.sv
// Function
// - Four independent hours counters, each with count, clear, setpoint, threshold.
// - While count coil is 1, add one per one-second base pulse.
// - Threshold contact high while actual value is at least the setpoint.
// - Actual value kept until clear coil fires, then set to zero.
// - Counter values held in retentive storage across switch-off.
// - Run/stop, power on/off and program changes never clear actual values.
// - One-second resolution; switch-off loses only the partial second.
// - Counter wide enough for well over a hundred years of seconds.
// - Setpoint in whole hours, adjustable, plus a display-enable flag.
// - Off time earlier than on time switches off on the following day.
// - Overlapping channels follow whichever channel switches first.
// - At power-up recompute switch outputs from all configured times.
// - Output drops during outage, stays off if an off time passed.
// - A channel may hold only an on time or only an off time.
// - Four channels per timer: day range, on and off time or unset.
// - Time switch outputs held open while the device is unpowered.
`timescale 1ns/10ps
`include "hcw_regs.svh"

module hcw_top
  import hcw_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = (`HCW_CLK_HZ / 1000) * `HCW_BASE_PULSE_MS,
  parameter int unsigned SCAN_MINUTES = `HCW_WEEK_MIN
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic retain_init_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] count_coil,
  input wire logic [3:0] hours_clear_coil,
  output logic [3:0] hours_reached,
  input wire logic power_ok,
  input wire logic [2:0] rtc_day,
  input wire logic [10:0] rtc_minute,
  output logic [7:0] week_contact,
  output logic irq
);

  localparam int NCFG = `HCW_NUM_CFG;

  // Storage
  logic [31:0] setpt_reg [`HCW_NUM_CNT];
  logic [31:0] cnt_reg [`HCW_NUM_CNT];
  logic [31:0] cfg_reg [NCFG];
  logic [11:0] irq_stat_reg;
  logic [11:0] irq_mask_reg;
  logic [3:0] reached_prev_reg;
  logic [7:0] contact_prev_reg;
  logic [7:0] ts_reg;
  logic [7:0] ts_next;
  hcw_ts_state_t state_reg;
  logic [2:0] scan_day_reg;
  logic [10:0] scan_min_reg;
  logic [13:0] scan_cnt_reg;
  logic [10:0] last_min_reg;
  logic pwr_meta_reg;
  logic pwr_reg;
  logic sec_tick;
  logic [2:0] eval_day;
  logic [10:0] eval_min;
  logic [NCFG-1:0] on_hit;
  logic [NCFG-1:0] off_hit;
  logic apply;
  logic ap_valid;
  logic dp_wr_reg;
  logic dp_rd_reg;
  logic rd_done_reg;
  logic [7:0] dp_addr_reg;
  logic rd_load;
  logic stat_rd_clr;
  logic [11:0] events;
  logic [13:0] next_now;
  logic [13:0] next_scan;

  // Step one minute forward through the week: returns {day, minute}
  function automatic logic [13:0] next_pos(input logic [2:0] d, input logic [10:0] m);
    if (m == `HCW_LAST_MIN) begin
      return {(d == `HCW_LAST_DAY) ? 3'h0 : d + 3'h1, 11'h000};
    end
    return {d, m + 11'h001};
  endfunction

  // Step back n minutes with week wrap, so a short replay still ends at now: returns {day, minute}
  function automatic logic [13:0] back_pos(input logic [2:0] d, input logic [10:0] m, input int n);
    int idx;
    idx = (int'(d) * `HCW_DAY_MIN + int'(m) + `HCW_WEEK_MIN - n) % `HCW_WEEK_MIN;
    return {3'(idx / `HCW_DAY_MIN), 11'(idx % `HCW_DAY_MIN)};
  endfunction

  // Channel configuration window decode, shared by read and write
  function automatic logic is_cfg(input logic [7:0] a);
    return (a[7:6] == `HCW_CFG_LO) || (a[7:6] == `HCW_CFG_HI);
  endfunction

  function automatic logic [4:0] cfg_idx(input logic [7:0] a);
    return 5'(a[7:2] - 6'h10);
  endfunction

  // Power pin comes from outside the clock domain
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pwr_meta_reg <= 1'b0;
      pwr_reg <= 1'b0;
    end else begin
      pwr_meta_reg <= power_ok;
      pwr_reg <= pwr_meta_reg;
    end
  end

  // Base pulse generator, stopped while unpowered
  hcw_prescaler #(
    .CYCLES(SEC_CYCLES)
  ) u_prescaler (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(pwr_reg),
    .tick(sec_tick)
  );

  // Hours counters; reset_n deliberately leaves the count alone
  genvar gi;
  generate
    for (gi = 0; gi < `HCW_NUM_CNT; gi++) begin : g_cnt
      // 32 bits of seconds cover about 136 years
      always_ff @(posedge core_clk) begin
        if (!retain_init_n) begin
          cnt_reg[gi] <= 32'h00000000;
        end else if (hours_clear_coil[gi]) begin
          cnt_reg[gi] <= 32'h00000000;
        end else if (sec_tick && count_coil[gi] && pwr_reg) begin
          cnt_reg[gi] <= cnt_reg[gi] + 32'h00000001;
        end
      end

      // Seconds against hours times 3600, widened so the product never wraps
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          hours_reached[gi] <= 1'b0;
        end else begin
          hours_reached[gi] <= {6'h00, cnt_reg[gi]} >=
            (38'(setpt_reg[gi][`HCW_SETPT_W-1:0]) * 38'(`HCW_SEC_PER_HOUR));
        end
      end
    end
  endgenerate

  // Weekly timer channel evaluators, all looking at one position of the week
  assign eval_day = (state_reg == HCW_SCAN) ? scan_day_reg : rtc_day;
  assign eval_min = (state_reg == HCW_SCAN) ? scan_min_reg : rtc_minute;

  generate
    for (gi = 0; gi < NCFG; gi++) begin : g_ch
      hcw_chan_eval u_eval (
        .cfg(cfg_reg[gi]),
        .day(eval_day),
        .minute(eval_min),
        .on_hit(on_hit[gi]),
        .off_hit(off_hit[gi])
      );
    end
  endgenerate

  // Events are applied in time order, so the channel switching first governs
  always_comb begin
    for (int t = 0; t < `HCW_NUM_TS; t++) begin
      if (|off_hit[t*`HCW_NUM_CH +: `HCW_NUM_CH]) begin
        ts_next[t] = 1'b0;
      end else if (|on_hit[t*`HCW_NUM_CH +: `HCW_NUM_CH]) begin
        ts_next[t] = 1'b1;
      end else begin
        ts_next[t] = ts_reg[t];
      end
    end
  end

  assign apply = (state_reg == HCW_SCAN) || ((state_reg == HCW_RUN) && (rtc_minute != last_min_reg));
  assign next_now = back_pos(rtc_day, rtc_minute, int'(SCAN_MINUTES) - 1);
  assign next_scan = next_pos(scan_day_reg, scan_min_reg);

  // Minute change detector on the calendar input
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      last_min_reg <= 11'h000;
    end else begin
      last_min_reg <= rtc_minute;
    end
  end

  // Sequencer: power-up replays the last SCAN_MINUTES minutes; a minute tick during replay is dropped, never applied.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= HCW_DOWN;
      scan_cnt_reg <= 14'h0000;
      scan_day_reg <= 3'h0;
      scan_min_reg <= 11'h000;
    end else begin
      case (state_reg)
        HCW_DOWN: begin
          if (pwr_reg) begin
            state_reg <= HCW_SCAN;
            scan_cnt_reg <= 14'h0000;
            scan_day_reg <= next_now[13:11];
            scan_min_reg <= next_now[10:0];
          end
        end
        HCW_SCAN: begin
          scan_day_reg <= next_scan[13:11];
          scan_min_reg <= next_scan[10:0];
          scan_cnt_reg <= scan_cnt_reg + 14'h0001;
          if (!pwr_reg) begin
            state_reg <= HCW_DOWN;
          end else if (scan_cnt_reg == 14'(SCAN_MINUTES - 1)) begin
            state_reg <= HCW_RUN;
          end
        end
        HCW_RUN: begin
          if (!pwr_reg) begin
            state_reg <= HCW_DOWN;
          end
        end
        default: begin
          state_reg <= HCW_DOWN;
        end
      endcase
    end
  end

  // Switch state is rebuilt from scratch, never restored from before the outage
  always_ff @(posedge core_clk) begin
    if (!reset_n || !pwr_reg || (state_reg == HCW_DOWN)) begin
      ts_reg <= 8'h00;
    end else if (apply) begin
      ts_reg <= ts_next;
    end
  end

  // Contacts stay open while unpowered or while the replay is running
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      week_contact <= 8'h00;
    end else begin
      week_contact <= (pwr_reg && (state_reg == HCW_RUN)) ? ts_reg : 8'h00;
    end
  end

  // AHB-Lite: writes complete with no wait, reads take one wait state
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = !(dp_rd_reg && !rd_done_reg);
  assign hresp = 1'b0;
  assign rd_load = dp_rd_reg && !rd_done_reg;
  assign stat_rd_clr = rd_load && (dp_addr_reg == `HCW_IRQ_STAT_ADDR);

  // Data phase tracking
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      rd_done_reg <= rd_load;
      if (ap_valid) begin
        dp_wr_reg <= hwrite;
        dp_rd_reg <= !hwrite;
        dp_addr_reg <= haddr[7:0];
      end else if (hready) begin
        dp_wr_reg <= 1'b0;
        dp_rd_reg <= 1'b0;
      end
    end
  end

  // Setpoints and display flags; only word writes are expected
  generate
    for (gi = 0; gi < `HCW_NUM_CNT; gi++) begin : g_setpt
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          setpt_reg[gi] <= `HCW_SETPT_RST;
        end else if (dp_wr_reg && (dp_addr_reg[7:4] == `HCW_SETPT_BASE) && (dp_addr_reg[3:2] == 2'(gi))) begin
          setpt_reg[gi] <= hwdata & 32'h800FFFFF;
        end
      end
    end
  endgenerate

  // Channel configuration words
  generate
    for (gi = 0; gi < NCFG; gi++) begin : g_cfg
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          cfg_reg[gi] <= `HCW_CFG_RST;
        end else if (dp_wr_reg && is_cfg(dp_addr_reg) && (cfg_idx(dp_addr_reg) == 5'(gi))) begin
          cfg_reg[gi] <= hwdata & 32'hFFFFFF77;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_mask_reg <= `HCW_MASK_RST;
    end else if (dp_wr_reg && (dp_addr_reg == `HCW_IRQ_MASK_ADDR)) begin
      irq_mask_reg <= hwdata[11:0];
    end
  end

  // Events: a threshold contact closing, or a time switch contact changing
  assign events = {week_contact ^ contact_prev_reg, hours_reached & ~reached_prev_reg};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reached_prev_reg <= 4'h0;
      contact_prev_reg <= 8'h00;
    end else begin
      reached_prev_reg <= hours_reached;
      contact_prev_reg <= week_contact;
    end
  end

  // Sticky status, cleared by reading it; a new event in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_stat_reg <= 12'h000;
    end else begin
      irq_stat_reg <= (stat_rd_clr ? 12'h000 : irq_stat_reg) | events;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data is loaded in the wait cycle and stands in the final data phase cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_load) begin
      if (dp_addr_reg[7:4] == `HCW_SETPT_BASE) begin
        hrdata <= setpt_reg[dp_addr_reg[3:2]];
      end else if (dp_addr_reg[7:4] == `HCW_ACTUAL_BASE) begin
        hrdata <= cnt_reg[dp_addr_reg[3:2]];
      end else if (dp_addr_reg == `HCW_STATUS_ADDR) begin
        hrdata <= {18'h00000, pwr_reg, state_reg == HCW_SCAN, week_contact, hours_reached};
      end else if (dp_addr_reg == `HCW_IRQ_STAT_ADDR) begin
        hrdata <= {20'h00000, irq_stat_reg};
      end else if (dp_addr_reg == `HCW_IRQ_MASK_ADDR) begin
        hrdata <= {20'h00000, irq_mask_reg};
      end else if (is_cfg(dp_addr_reg)) begin
        hrdata <= cfg_reg[cfg_idx(dp_addr_reg)];
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

endmodule

// File: test/hcw_ladder_model.sv
`timescale 1ns/10ps

module hcw_ladder_model
  import hcw_pkg::*;
(
  input wire logic core_clk,
  input wire logic [3:0] want_count,
  input wire logic [3:0] want_clear,
  input wire logic [3:0] hours_reached,
  output logic [3:0] count_coil,
  output logic [3:0] hours_clear_coil,
  output logic warn_lamp
);
  // Coils start released so nothing counts before the first rung scan
  initial begin
    count_coil = 4'h0;
    hours_clear_coil = 4'h0;
  end

  // Rungs are scanned once per clock, so coils follow requests one cycle late
  always @(posedge core_clk) begin
    count_coil <= want_count;
    hours_clear_coil <= want_clear;
  end

  // Warning light reads the threshold contacts
  assign warn_lamp = |hours_reached;
endmodule

// File: test/hcw_top_properties.sv
`timescale 1ns/10ps

module hcw_top_properties
  import hcw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic retain_init_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] count_coil,
  input wire logic [3:0] hours_clear_coil,
  input wire logic [3:0] hours_reached,
  input wire logic power_ok,
  input wire logic [2:0] rtc_day,
  input wire logic [10:0] rtc_minute,
  input wire logic [7:0] week_contact,
  input wire logic irq
);
  logic rd_req;
  logic wr_req;

  // Transfers the slave takes at this edge
  assign rd_req = hsel & hready & htrans[1] & ~hwrite;
  assign wr_req = hsel & hready & htrans[1] & hwrite;

  sequence s_wait;
    !hreadyout;
  endsequence
  sequence s_data;
    hreadyout;
  endsequence

  property p_read_wait;
    @(posedge core_clk) disable iff (!reset_n) rd_req |=> s_wait ##1 s_data;
  endproperty
  property p_write_ready;
    @(posedge core_clk) disable iff (!reset_n) wr_req |=> s_data;
  endproperty
  property p_idle_ready;
    @(posedge core_clk) disable iff (!reset_n) $past(rd_req) == 1'b0 |-> hreadyout;
  endproperty
  property p_okay;
    @(posedge core_clk) disable iff (!reset_n) hresp == 1'b0;
  endproperty
  // Read data may only move while a read is in flight
  property p_hold_data;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(hrdata) |-> $past(hreadyout) == 1'b0 || $past(rd_req);
  endproperty
  // No disable here: the reset itself is what is being checked
  property p_reset_outs;
    @(posedge core_clk) !reset_n |=> hrdata == 32'h0 && hours_reached == 4'h0 && week_contact == 8'h0 && hreadyout;
  endproperty
  property p_reset_irq;
    @(posedge core_clk) !reset_n |=> !irq;
  endproperty
  // Sync flops plus the contact register stay well inside six cycles
  property p_unpowered_open;
    @(posedge core_clk) disable iff (!reset_n) !power_ok [*6] |-> week_contact == 8'h0;
  endproperty

  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  a_write_ready: assert property (p_write_ready) else $error("write stalled");
  a_idle_ready: assert property (p_idle_ready) else $error("ready low outside a read");
  a_okay: assert property (p_okay) else $error("error response seen");
  a_hold_data: assert property (p_hold_data) else $error("read data moved without a read");
  a_reset_outs: assert property (p_reset_outs) else $error("outputs not cleared by reset");
  a_reset_irq: assert property (p_reset_irq) else $error("interrupt high after reset");
  a_unpowered_open: assert property (p_unpowered_open) else $error("contact closed while unpowered");
endmodule

bind hcw_top hcw_top_properties u_props (
  .core_clk(core_clk), .reset_n(reset_n), .retain_init_n(retain_init_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .count_coil(count_coil), .hours_clear_coil(hours_clear_coil),
  .hours_reached(hours_reached), .power_ok(power_ok), .rtc_day(rtc_day), .rtc_minute(rtc_minute),
  .week_contact(week_contact), .irq(irq)
);

// File: test/testbench.sv
`timescale 1ns/10ps

module testbench;
  import hcw_pkg::*;
  // Ten cycles per second keeps an hour of counting near 36000 cycles
  localparam int unsigned SEC = 10;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic retain_init_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] count_coil;
  logic [3:0] hours_clear_coil;
  logic [3:0] hours_reached;
  logic power_ok = 1'b1;
  logic [2:0] rtc_day = 3'h0;
  logic [10:0] rtc_minute = 11'h0;
  logic [7:0] week_contact;
  logic irq;
  logic [3:0] want_count = 4'h0;
  logic [3:0] want_clear = 4'h0;
  logic lamp;
  int errors = 0;
  int n_checks = 0;

  assign hready = hreadyout;
  always #50 core_clk = ~core_clk;

  hcw_top #(.SEC_CYCLES(SEC), .SCAN_MINUTES(20)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .retain_init_n(retain_init_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .count_coil(count_coil), .hours_clear_coil(hours_clear_coil),
    .hours_reached(hours_reached), .power_ok(power_ok), .rtc_day(rtc_day), .rtc_minute(rtc_minute),
    .week_contact(week_contact), .irq(irq));

  hcw_ladder_model partner (.core_clk(core_clk), .want_count(want_count), .want_clear(want_clear),
    .hours_reached(hours_reached), .count_coil(count_coil), .hours_clear_coil(hours_clear_coil), .warn_lamp(lamp));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // No cycle count is assumed; a dead slave is left to the watchdog
  task wait_ready;
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'b1);
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    r = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask

  task set_time(input logic [2:0] d, input logic [10:0] m);
    @(posedge core_clk);
    rtc_day <= d;
    rtc_minute <= m;
    cyc(4);
  endtask

  // Coil windows of exactly 50 cycles hold exactly five base pulses
  task t_counting;
    @(posedge core_clk);
    want_count <= 4'h3;
    want_clear <= 4'h2;
    cyc(50);
    want_count <= 4'h0;
    want_clear <= 4'h0;
    cyc(3);
    rd_chk("actual0", 32'h20, 32'h5);
    rd_chk("actual1", 32'h24, 32'h0);
    rd_chk("actual2", 32'h28, 32'h0);
    $display("test counting done");
  endtask

  task t_regs;
    wr(32'h10, 32'hFFFFFFFF);
    rd_chk("setpoint0", 32'h10, 32'h800FFFFF);
    wr(32'h20, 32'h00001234);
    rd_chk("actual0 read only", 32'h20, 32'h5);
    rd_chk("unmapped", 32'h3C, 32'h0);
    $display("test registers done");
  endtask

  task t_threshold;
    logic [31:0] r;
    wr(32'h1C, 32'h1);
    wr(32'h14, 32'h1);
    wr(32'h18, 32'h1);
    wr(32'h38, 32'h008);
    ahb(1'b0, 32'h34, 32'h0, r);
    @(posedge core_clk);
    want_count <= 4'h8;
    cyc(35990);
    want_count <= 4'h0;
    cyc(3);
    chk("reached at 3599 s", 32'h0, {31'h0, hours_reached[3]});
    chk("irq early", 32'h0, {31'h0, irq});
    chk("lamp early", 32'h0, {31'h0, lamp});
    want_count <= 4'h8;
    cyc(10);
    want_count <= 4'h0;
    cyc(5);
    chk("reached at 3600 s", 32'h1, {31'h0, hours_reached[3]});
    chk("irq", 32'h1, {31'h0, irq});
    chk("lamp", 32'h1, {31'h0, lamp});
    rd_chk("irq status", 32'h34, 32'h008);
    chk("irq after read", 32'h0, {31'h0, irq});
    want_clear <= 4'h8;
    cyc(3);
    want_clear <= 4'h0;
    cyc(3);
    chk("reached after clear", 32'h0, {31'h0, hours_reached[3]});
    rd_chk("actual3 cleared", 32'h2C, 32'h0);
    $display("test threshold done");
  endtask

  task t_retain;
    @(posedge core_clk);
    power_ok <= 1'b0;
    cyc(20);
    power_ok <= 1'b1;
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(40);
    rd_chk("actual0 kept", 32'h20, 32'h5);
    $display("test retention done");
  endtask

  // Monday only: on 22:00, off 06:00, so the off lands on Tuesday
  task t_week;
    set_time(3'h0, 11'h527);
    wr(32'h40, 32'h968D2800);
    set_time(3'h0, 11'h528);
    chk("on monday 22:00", 32'h1, {31'h0, week_contact[0]});
    set_time(3'h1, 11'h167);
    chk("still on tuesday", 32'h1, {31'h0, week_contact[0]});
    set_time(3'h1, 11'h168);
    chk("off tuesday 06:00", 32'h0, {31'h0, week_contact[0]});
    set_time(3'h1, 11'h528);
    chk("tuesday outside range", 32'h0, {31'h0, week_contact[0]});
    $display("test week switch done");
  endtask

  task t_power;
    set_time(3'h0, 11'h527);
    set_time(3'h0, 11'h528);
    power_ok <= 1'b0;
    cyc(8);
    chk("open while unpowered", 32'h0, {31'h0, week_contact[0]});
    rtc_minute <= 11'h52D;
    power_ok <= 1'b1;
    cyc(40);
    chk("rebuilt on", 32'h1, {31'h0, week_contact[0]});
    power_ok <= 1'b0;
    cyc(8);
    rtc_day <= 3'h1;
    rtc_minute <= 11'h172;
    power_ok <= 1'b1;
    cyc(40);
    chk("off passed in outage", 32'h0, {31'h0, week_contact[0]});
    $display("test power loss done");
  endtask

  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Tests need about 37000 cycles; allow some 60000
  initial begin
    #6000000;
    errors++;
    report_and_stop;
  end

  initial begin
    cyc(6);
    reset_n <= 1'b1;
    retain_init_n <= 1'b1;
    cyc(40);
    t_counting;
    t_regs;
    t_threshold;
    t_retain;
    t_week;
    t_power;
    report_and_stop;
  end
endmodule
